// ---- rtl/presence_consts.vh ----
`ifndef PRESENCE_CONSTS_VH
`define PRESENCE_CONSTS_VH
// =====================================================
// classification thresholds: voltage in percent, frequency in tenths of percent of nominal
`define DEAD_PCT 8'h09
`define LIVE_PCT 8'h0C
`define FREQ_LOW_PCT_DEF 16'h0384
`define FREQ_HIGH_PCT_DEF 16'h044C
`define FREQ_HYST_PCT_DEF 16'h0019
`define PCT_SCALE 8'h64
`define PCT10_SCALE 16'h03E8
// =====================================================
// encodings
`define FREQ_OFF 2'h0
`define FREQ_OK 2'h1
`define FREQ_HIGH 2'h2
`define PHASES_ONE 2'h1
`define PHASES_THREE 2'h3
`define EVT_GEN_BIT 2
`define FS_400_SHIFT 4'h2
`define FS_100_SHIFT 4'h0
`endif

// ---- rtl/volt_hyst.v ----
`include "presence_consts.vh"
// =====================================================
// dead/live hysteresis for a set of up to six voltages
module volt_hyst #(
  parameter W = 16
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire sample_i,
  input wire [W-1:0] nominal_i,
  input wire [6*W-1:0] volts_i,
  input wire [5:0] use_mask_i,
  output wire live_o
);
  reg live_r;
  wire [W+7:0] dead_lim;
  wire [W+7:0] live_lim;
  reg any_above;
  reg all_below;
  integer k;
  wire [W-1:0] vk [0:5];
  genvar g;
  assign dead_lim = nominal_i * `DEAD_PCT;
  assign live_lim = nominal_i * `LIVE_PCT;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : sl
      assign vk[g] = volts_i[g*W +: W];
    end
  endgenerate
  always @*
  begin
    any_above = 1'b0;
    all_below = 1'b1;
    for (k = 0; k < 6; k = k + 1)
    begin
      if (use_mask_i[k])
      begin
        // compare v*100 against nominal*pct to avoid division
        if (({8'h00, vk[k]} * `PCT_SCALE) > {8'h00, live_lim})
          any_above = 1'b1;
        if (!(({8'h00, vk[k]} * `PCT_SCALE) < {8'h00, dead_lim}))
          all_below = 1'b0;
      end
    end
  end
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      live_r <= 1'b0;
    else if (sample_i)
    begin
      if (any_above)
        live_r <= 1'b1;
      else if (all_below)
        live_r <= 1'b0;
    end
  end
  assign live_o = live_r;
endmodule // volt_hyst

// ---- rtl/freq_hyst.v ----
`include "presence_consts.vh"
// =====================================================
// frequency band classifier, thresholds in tenths of percent
module freq_hyst #(
  parameter W = 16
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire sample_i,
  input wire [W-1:0] nominal_i,
  input wire [W-1:0] freq_i,
  input wire [15:0] low_pct10_i,
  input wire [15:0] high_pct10_i,
  input wire [15:0] hyst_pct10_i,
  output wire [1:0] state_o
);
  reg [1:0] state_r;
  wire [W+15:0] f_s;
  wire [W+15:0] lo;
  wire [W+15:0] lo_h;
  wire [W+15:0] hi;
  wire [W+15:0] hi_h;
  assign f_s = freq_i * `PCT10_SCALE;
  assign lo = nominal_i * low_pct10_i;
  assign lo_h = nominal_i * (low_pct10_i + hyst_pct10_i);
  assign hi = nominal_i * high_pct10_i;
  assign hi_h = nominal_i * (high_pct10_i - hyst_pct10_i);
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_r <= `FREQ_OFF;
    else if (sample_i)
    begin
      if (f_s < lo)
        state_r <= `FREQ_OFF;
      else if (f_s > hi)
        state_r <= `FREQ_HIGH;
      else if ((f_s > lo_h) && (f_s < hi_h))
        state_r <= `FREQ_OK;
    end
  end
  assign state_o = state_r;
endmodule // freq_hyst

// ---- rtl/bus_and_mains_presence_detector.v ----
`include "presence_consts.vh"
// Function
// - external gen sensor overrides internal measurement
// - external input active means gen bus dead
// - dead only when all used voltages below 9%
// - live above 12%, hold between
// - phase count selects three phase-phase voltages or one phase-neutral voltage
// - three phase adds the phase-neutral voltages when enabled
// - event bit 2 logs dead/live change events
// - gen voltage output follows live status
// - load dead input inactive means live
// - else derive load from mains, gen, breakers
// - load voltage output follows load live
// - mains select chooses internal or external
// - external mains active means in tolerance
// - parallel protection trip forces mains off when parallel with mains
// - low threshold, hysteresis band above it
// - high threshold, hysteresis band below it
// - inside hysteresis band keep previous status
// - off below, ok between, high above
// - internal mains ok needs a mains phase count of one or three; external mains ignores it
// - full scale selects 400V or 100V range
module bus_and_mains_presence_detector #(
  parameter W = 16
) (
  input wire CLOCK_I,
  input wire RSTN_I,
  input wire SAMPLE_I,
  input wire [W-1:0] GEN_NOMINAL_I,
  input wire [W-1:0] GEN_VPP_0_I,
  input wire [W-1:0] GEN_VPP_1_I,
  input wire [W-1:0] GEN_VPP_2_I,
  input wire [W-1:0] GEN_VPN_0_I,
  input wire [W-1:0] GEN_VPN_1_I,
  input wire [W-1:0] GEN_VPN_2_I,
  input wire [1:0] GEN_PHASES_I,
  input wire GEN_PN_CHECK_I,
  input wire GEN_FULL_SCALE_100_I,
  input wire GEN_EXT_SEL_I,
  input wire GEN_BUS_DEAD_INPUT_FUNCTION_I,
  input wire [7:0] EVENT_ENABLE_I,
  input wire LOAD_EXT_SEL_I,
  input wire LOAD_BUS_DEAD_INPUT_FUNCTION_I,
  input wire MAINS_BREAKER_CLOSED_I,
  input wire GEN_BREAKER_CLOSED_I,
  input wire [1:0] MAINS_PHASES_I,
  input wire MAINS_EXT_SEL_I,
  input wire EXTERNAL_MAINS_OK_INPUT_FUNCTION_I,
  input wire MAINS_VOLT_OK_I,
  input wire PARALLEL_PROTECTIONS_TRIP_I,
  input wire PARALLEL_WITH_MAINS_I,
  input wire [W-1:0] FREQ_NOMINAL_I,
  input wire [W-1:0] FREQ_I,
  input wire [15:0] FREQ_LOW_PCT10_I,
  input wire [15:0] FREQ_HIGH_PCT10_I,
  input wire [15:0] FREQ_HYST_PCT10_I,
  output wire GEN_VOLTAGE_OUTPUT_FUNCTION_O,
  output wire LOAD_VOLTAGE_OUTPUT_FUNCTION_O,
  output wire GEN_BUS_LIVE_O,
  output wire LOAD_BUS_LIVE_O,
  output wire [1:0] FREQ_STATUS_O,
  output wire MAINS_OK_O,
  output reg GEN_BUS_DEAD_EVENT_O,
  output reg GEN_BUS_LIVE_EVENT_O,
  output reg STATUS_CHANGE_O
);
  // =====================================================
  // pin synchronisers; stage one feeds only stage two
  reg [3:0] pin_s1_r;
  reg [3:0] pin_s2_r;
  wire gen_dead_pin;
  wire load_dead_pin;
  wire mains_ok_pin;
  wire ppr_trip_pin;
  always @(posedge CLOCK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end
    else
    begin
      pin_s1_r <= {PARALLEL_PROTECTIONS_TRIP_I, EXTERNAL_MAINS_OK_INPUT_FUNCTION_I,
                   LOAD_BUS_DEAD_INPUT_FUNCTION_I, GEN_BUS_DEAD_INPUT_FUNCTION_I};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign gen_dead_pin = pin_s2_r[0];
  assign load_dead_pin = pin_s2_r[1];
  assign mains_ok_pin = pin_s2_r[2];
  assign ppr_trip_pin = pin_s2_r[3];

  // =====================================================
  // voltage scaling and phase selection
  function [W-1:0] scale_fs;
    input [W-1:0] raw;
    input fs100;
    begin
      // 400V range raw counts are a quarter of the 100V ones
      if (fs100)
        scale_fs = raw >> `FS_100_SHIFT;
      else
        scale_fs = raw << `FS_400_SHIFT;
    end
  endfunction
  wire [6*W-1:0] gen_volts;
  wire [5:0] gen_mask;
  wire three_ph;
  assign three_ph = (GEN_PHASES_I == `PHASES_THREE);
  assign gen_volts = {scale_fs(GEN_VPN_2_I, GEN_FULL_SCALE_100_I),
                      scale_fs(GEN_VPN_1_I, GEN_FULL_SCALE_100_I),
                      scale_fs(GEN_VPN_0_I, GEN_FULL_SCALE_100_I),
                      scale_fs(GEN_VPP_2_I, GEN_FULL_SCALE_100_I),
                      scale_fs(GEN_VPP_1_I, GEN_FULL_SCALE_100_I),
                      scale_fs(GEN_VPP_0_I, GEN_FULL_SCALE_100_I)};
  // single phase uses only the phase-neutral voltage of phase 0
  assign gen_mask = three_ph ? {{3{GEN_PN_CHECK_I}}, 3'h7} : 6'h08;
  wire int_live;
  volt_hyst #(.W(W)) u_gen (
    .clk_i(CLOCK_I),
    .rst_n_i(RSTN_I),
    .sample_i(SAMPLE_I),
    .nominal_i(GEN_NOMINAL_I),
    .volts_i(gen_volts),
    .use_mask_i(gen_mask),
    .live_o(int_live)
  );
  // mains voltages are sampled elsewhere; this block only gates MAINS_VOLT_OK_I with a valid phase count
  wire mains_volt_ok;
  assign mains_volt_ok = MAINS_VOLT_OK_I &
    ((MAINS_PHASES_I == `PHASES_THREE) | (MAINS_PHASES_I == `PHASES_ONE));

  // =====================================================
  // frequency classifier
  wire [1:0] freq_st;
  freq_hyst #(.W(W)) u_freq (
    .clk_i(CLOCK_I),
    .rst_n_i(RSTN_I),
    .sample_i(SAMPLE_I),
    .nominal_i(FREQ_NOMINAL_I),
    .freq_i(FREQ_I),
    .low_pct10_i(FREQ_LOW_PCT10_I),
    .high_pct10_i(FREQ_HIGH_PCT10_I),
    .hyst_pct10_i(FREQ_HYST_PCT10_I),
    .state_o(freq_st)
  );

  // =====================================================
  // status registers, updated per sample
  reg gen_live_r;
  reg load_live_r;
  reg mains_ok_r;
  reg [1:0] freq_r;
  reg gen_live_nxt;
  reg load_live_nxt;
  reg mains_ok_nxt;
  always @*
  begin
    if (GEN_EXT_SEL_I)
      gen_live_nxt = ~gen_dead_pin;
    else
      gen_live_nxt = int_live;
    if (MAINS_EXT_SEL_I)
      mains_ok_nxt = mains_ok_pin;
    else
      mains_ok_nxt = mains_volt_ok & (freq_st == `FREQ_OK);
    if (ppr_trip_pin & PARALLEL_WITH_MAINS_I)
      mains_ok_nxt = 1'b0;
    if (LOAD_EXT_SEL_I)
      load_live_nxt = ~load_dead_pin;
    else
      load_live_nxt = (mains_ok_nxt & MAINS_BREAKER_CLOSED_I) |
                      (gen_live_nxt & GEN_BREAKER_CLOSED_I);
  end
  // the internal classifiers update on the sample edge, so status follows one cycle later
  reg sample_d_r;
  always @(posedge CLOCK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      sample_d_r <= 1'b0;
      gen_live_r <= 1'b0;
      load_live_r <= 1'b0;
      mains_ok_r <= 1'b0;
      freq_r <= `FREQ_OFF;
      GEN_BUS_DEAD_EVENT_O <= 1'b0;
      GEN_BUS_LIVE_EVENT_O <= 1'b0;
      STATUS_CHANGE_O <= 1'b0;
    end
    else
    begin
      sample_d_r <= SAMPLE_I;
      GEN_BUS_DEAD_EVENT_O <= 1'b0;
      GEN_BUS_LIVE_EVENT_O <= 1'b0;
      STATUS_CHANGE_O <= 1'b0;
      if (sample_d_r)
      begin
        gen_live_r <= gen_live_nxt;
        load_live_r <= load_live_nxt;
        mains_ok_r <= mains_ok_nxt;
        freq_r <= freq_st;
        STATUS_CHANGE_O <= (gen_live_nxt != gen_live_r) | (load_live_nxt != load_live_r) |
                           (mains_ok_nxt != mains_ok_r) | (freq_st != freq_r);
        if (EVENT_ENABLE_I[`EVT_GEN_BIT] && (gen_live_nxt != gen_live_r))
        begin
          GEN_BUS_DEAD_EVENT_O <= ~gen_live_nxt;
          GEN_BUS_LIVE_EVENT_O <= gen_live_nxt;
        end
      end
    end
  end
  assign GEN_BUS_LIVE_O = gen_live_r;
  assign GEN_VOLTAGE_OUTPUT_FUNCTION_O = gen_live_r;
  assign LOAD_BUS_LIVE_O = load_live_r;
  assign LOAD_VOLTAGE_OUTPUT_FUNCTION_O = load_live_r;
  assign MAINS_OK_O = mains_ok_r;
  assign FREQ_STATUS_O = freq_r;
endmodule // bus_and_mains_presence_detector

// ---- tb/presence_chk_asserts.sv ----
// ========================================
// port checker for the presence detector
module presence_chk (
  input wire CLOCK_I,
  input wire RSTN_I,
  input wire SAMPLE_I,
  input wire [7:0] EVENT_ENABLE_I,
  input wire GEN_EXT_SEL_I,
  input wire GEN_BUS_DEAD_INPUT_FUNCTION_I,
  input wire PARALLEL_PROTECTIONS_TRIP_I,
  input wire PARALLEL_WITH_MAINS_I,
  input wire GEN_VOLTAGE_OUTPUT_FUNCTION_O,
  input wire LOAD_VOLTAGE_OUTPUT_FUNCTION_O,
  input wire GEN_BUS_LIVE_O,
  input wire LOAD_BUS_LIVE_O,
  input wire [1:0] FREQ_STATUS_O,
  input wire MAINS_OK_O,
  input wire GEN_BUS_DEAD_EVENT_O,
  input wire GEN_BUS_LIVE_EVENT_O,
  input wire STATUS_CHANGE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK_I);
  endclocking
  default disable iff (!RSTN_I);
  a_gen_mirror:
    assert property (GEN_VOLTAGE_OUTPUT_FUNCTION_O == GEN_BUS_LIVE_O) else $error("gen out");
  a_load_mirror:
    assert property (LOAD_VOLTAGE_OUTPUT_FUNCTION_O == LOAD_BUS_LIVE_O) else $error("load out");
  a_live_event:
    assert property (GEN_BUS_LIVE_EVENT_O == ($rose(GEN_BUS_LIVE_O) && EVENT_ENABLE_I[2]))
    else $error("live event");
  a_dead_event:
    assert property (GEN_BUS_DEAD_EVENT_O == ($fell(GEN_BUS_LIVE_O) && EVENT_ENABLE_I[2]))
    else $error("dead event");
  a_change_pulse:
    assert property ($changed({GEN_BUS_LIVE_O, LOAD_BUS_LIVE_O, FREQ_STATUS_O})
      |-> STATUS_CHANGE_O) else $error("no change pulse");
  a_sample_only:
    assert property ($changed(GEN_BUS_LIVE_O) |-> $past(SAMPLE_I, 2)) else $error("unsampled");
  a_freq_code:
    assert property (FREQ_STATUS_O != 2'h3) else $error("freq code");
  // six cycles lets the two-stage pin synchroniser settle first
  a_ext_dead:
    assert property ((GEN_EXT_SEL_I && GEN_BUS_DEAD_INPUT_FUNCTION_I)[*6] ##0 SAMPLE_I
      ##1 GEN_EXT_SEL_I |-> ##1 !GEN_BUS_LIVE_O) else $error("ext dead");
  // the select and with-mains levels are read unsynchronised one edge after the sample
  a_trip_off:
    assert property ((PARALLEL_PROTECTIONS_TRIP_I && PARALLEL_WITH_MAINS_I)[*6] ##0 SAMPLE_I
      ##1 PARALLEL_WITH_MAINS_I |-> ##1 !MAINS_OK_O) else $error("trip");
endmodule // presence_chk
bind bus_and_mains_presence_detector presence_chk chk_u (.*);

// ---- tb/bus_sensor_model.sv ----
// ========================================
// sensor front end: strobes a fresh sample every eight cycles
module bus_sensor_model (
  input wire clk_i,
  input wire [15:0] lvl_i,
  input wire [15:0] hz_i,
  output logic smp_o = 1'h0,
  output logic [15:0] v_o = 16'h0000,
  output logic [15:0] f_o = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_r = 3'h0;
  always @(posedge clk_i)
  begin
    cnt_r <= cnt_r + 3'h1;
    smp_o <= (cnt_r == 3'h0);
    v_o <= lvl_i;
    f_o <= hz_i;
  end
endmodule // bus_sensor_model

// ---- tb/bus_and_mains_presence_detector_test.sv ----
// ========================================
// presence detector bench
module bus_and_mains_presence_detector_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK_I = 0, RSTN_I = 0, GEN_PN_CHECK_I = 0, GEN_FULL_SCALE_100_I = 1;
  logic GEN_EXT_SEL_I = 0, GEN_BUS_DEAD_INPUT_FUNCTION_I = 0, LOAD_EXT_SEL_I = 0;
  logic LOAD_BUS_DEAD_INPUT_FUNCTION_I = 0, MAINS_BREAKER_CLOSED_I = 0;
  logic GEN_BREAKER_CLOSED_I = 0, MAINS_EXT_SEL_I = 0, EXTERNAL_MAINS_OK_INPUT_FUNCTION_I = 0;
  logic MAINS_VOLT_OK_I = 1, PARALLEL_PROTECTIONS_TRIP_I = 0, PARALLEL_WITH_MAINS_I = 0;
  logic [1:0] GEN_PHASES_I = 2'h3, MAINS_PHASES_I = 2'h3;
  logic [7:0] EVENT_ENABLE_I = 8'h04;
  logic [15:0] GEN_NOMINAL_I = 16'h0190, FREQ_NOMINAL_I = 16'h01F4;
  logic [15:0] FREQ_LOW_PCT10_I = 16'h0384, FREQ_HIGH_PCT10_I = 16'h044C;
  logic [15:0] FREQ_HYST_PCT10_I = 16'h0019, lvl = 0, pn = 0, hz = 16'h01F4;
  wire SAMPLE_I, GEN_VOLTAGE_OUTPUT_FUNCTION_O, LOAD_VOLTAGE_OUTPUT_FUNCTION_O, MAINS_OK_O;
  wire GEN_BUS_LIVE_O, LOAD_BUS_LIVE_O, GEN_BUS_DEAD_EVENT_O, GEN_BUS_LIVE_EVENT_O;
  wire STATUS_CHANGE_O;
  wire [1:0] FREQ_STATUS_O;
  wire [15:0] vpp, FREQ_I;
  wire [15:0] GEN_VPP_0_I = vpp, GEN_VPP_1_I = vpp, GEN_VPP_2_I = vpp;
  wire [15:0] GEN_VPN_0_I = pn, GEN_VPN_1_I = pn, GEN_VPN_2_I = pn;
  int num_errors = 0, check_count = 0, n_live = 0, n_dead = 0, n_chg = 0;
  bus_and_mains_presence_detector #(.W(16)) dut_u (.*);
  bus_sensor_model sm_u (.clk_i(CLOCK_I), .lvl_i(lvl), .hz_i(hz), .smp_o(SAMPLE_I),
    .v_o(vpp), .f_o(FREQ_I));
  initial forever #4 CLOCK_I = ~CLOCK_I;
  // event pulses last one cycle, so they are tallied here
  always @(posedge CLOCK_I)
  begin
    n_live += (GEN_BUS_LIVE_EVENT_O === 1'h1);
    n_dead += (GEN_BUS_DEAD_EVENT_O === 1'h1);
    n_chg += (STATUS_CHANGE_O === 1'h1);
  end
  task chk(input logic [3:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %0d want %0d", $time, got, exp);
    end
  endtask
  // sample period plus pin sync plus output latency
  task settle;
    repeat (24) @(posedge CLOCK_I);
  endtask
  task gen_step(input logic [15:0] l, p, input logic [2:0] c, input logic e);
    @(posedge CLOCK_I);
    lvl <= l;
    pn <= p;
    GEN_PN_CHECK_I <= c[2];
    GEN_PHASES_I <= c[1] ? 2'h1 : 2'h3;
    GEN_FULL_SCALE_100_I <= c[0];
    settle;
    chk(GEN_BUS_LIVE_O, e);
    chk(GEN_VOLTAGE_OUTPUT_FUNCTION_O, e);
  endtask
  task t_gen;
    gen_step(16'h0032, 16'h0000, 3'h1, 1'h1);
    gen_step(16'h0028, 16'h0000, 3'h1, 1'h1);
    gen_step(16'h0023, 16'h0000, 3'h1, 1'h0);
    gen_step(16'h0030, 16'h0000, 3'h1, 1'h0);
    gen_step(16'h0031, 16'h0000, 3'h1, 1'h1);
    gen_step(16'h0000, 16'h0032, 3'h1, 1'h0);
    gen_step(16'h0000, 16'h0032, 3'h5, 1'h1);
    gen_step(16'h0032, 16'h0000, 3'h3, 1'h0);
    gen_step(16'h0000, 16'h0032, 3'h3, 1'h1);
    gen_step(16'h000D, 16'h0000, 3'h1, 1'h0);
    gen_step(16'h000D, 16'h0000, 3'h0, 1'h1);
    EVENT_ENABLE_I <= 8'h00;
    gen_step(16'h0000, 16'h0000, 3'h1, 1'h0);
    chk(n_live, 4'h5);
    chk(n_dead, 4'h4);
    EVENT_ENABLE_I <= 8'h04;
    GEN_EXT_SEL_I <= 1'h1;
    GEN_BUS_DEAD_INPUT_FUNCTION_I <= 1'h1;
    gen_step(16'h0032, 16'h0000, 3'h1, 1'h0);
    GEN_BUS_DEAD_INPUT_FUNCTION_I <= 1'h0;
    gen_step(16'h0000, 16'h0000, 3'h1, 1'h1);
    GEN_EXT_SEL_I <= 1'h0;
    gen_step(16'h0000, 16'h0000, 3'h1, 1'h0);
  endtask
  task t_freq;
    logic [15:0] f[9];
    logic [1:0] e[9];
    int c0;
    f = '{16'h01F4, 16'h021C, 16'h0227, 16'h021C, 16'h0219, 16'h01C7, 16'h01C1,
      16'h01CE, 16'h01CF};
    e = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h1};
    c0 = n_chg;
    for (int i = 0; i < 9; i++)
    begin
      @(posedge CLOCK_I);
      hz <= f[i];
      settle;
      chk(FREQ_STATUS_O, e[i]);
    end
    // four band changes, each moving frequency and internal mains status in one sample
    chk(n_chg - c0, 4'h4);
  endtask
  task m_step(input logic [4:0] c, input logic e);
    @(posedge CLOCK_I);
    {MAINS_EXT_SEL_I, EXTERNAL_MAINS_OK_INPUT_FUNCTION_I, MAINS_VOLT_OK_I} <= c[4:2];
    PARALLEL_PROTECTIONS_TRIP_I <= c[1];
    PARALLEL_WITH_MAINS_I <= c[1];
    MAINS_PHASES_I <= c[0] ? 2'h1 : 2'h3;
    settle;
    chk(MAINS_OK_O, e);
  endtask
  task l_step(input logic [3:0] c, input logic e);
    @(posedge CLOCK_I);
    {LOAD_EXT_SEL_I, LOAD_BUS_DEAD_INPUT_FUNCTION_I} <= c[3:2];
    {MAINS_BREAKER_CLOSED_I, GEN_BREAKER_CLOSED_I} <= c[1:0];
    settle;
    chk(LOAD_BUS_LIVE_O, e);
    chk(LOAD_VOLTAGE_OUTPUT_FUNCTION_O, e);
  endtask
  task t_mains_load;
    m_step(5'h04, 1'h1);
    m_step(5'h05, 1'h1);
    m_step(5'h00, 1'h0);
    m_step(5'h18, 1'h1);
    m_step(5'h10, 1'h0);
    m_step(5'h1A, 1'h0);
    m_step(5'h18, 1'h1);
    l_step(4'hC, 1'h0);
    l_step(4'h8, 1'h1);
    l_step(4'h2, 1'h1);
    l_step(4'h1, 1'h0);
    gen_step(16'h0032, 16'h0000, 3'h1, 1'h1);
    l_step(4'h1, 1'h1);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge CLOCK_I);
    num_errors++;
    complete_run;
  end
  initial
  begin
    repeat (16) @(posedge CLOCK_I);
    chk({GEN_BUS_LIVE_O, LOAD_BUS_LIVE_O, FREQ_STATUS_O}, 4'h0);
    RSTN_I <= 1'h1;
    t_gen;
    t_freq;
    t_mains_load;
    complete_run;
  end
endmodule // bus_and_mains_presence_detector_test
